// [verilog/crf_core.sv]
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "crf_cfg.svh"
// Notes on behaviour
// - 16-bit pointer to next instruction
// - 16-bit accumulator, byte ops use low byte
// - 16-bit temp accumulator is second operand
// - index, extra and stack pointers, 16-bit
// - status word: bank select high, flags low
// - half carry from bit 3 to 4
// - interrupts only while enable set; reset clears
// - service only levels above the mask
// - negative flag follows result msb
// - zero flag on zero result
// - overflow flag on signed overflow
// - carry from bit 7, shift-out on shifts
// - eight-register banks, 16 or 8 banks
// - bank select picks the active bank
// - 64k map: io low, data, program high
module crf_core #(
   parameter int BANKS = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] irq_level,
   input wire logic irq_req,
   output logic irq_take
);
   localparam int GW = $clog2(BANKS*8);
   typedef enum logic [1:0] {
      CRF_ST_IDLE = 2'b01,
      CRF_ST_MEMRD = 2'b10
   } crf_st_t;

   // ==========================================================
   // helpers
   function automatic logic [1:0] crf_level(input logic [1:0] code);
      // 00 and 01 both mean level 1 (highest)
      crf_level = (code == 2'b00) ? 2'd1 : ((code == 2'b01) ? 2'd1 : code);
   endfunction

   function automatic logic [15:0] crf_bank_base(input logic [7:0] sel);
      crf_bank_base = `CRF_BANK_BASE + {11'h000, sel[4:0]} * 16'(`CRF_BANK_SPAN);
   endfunction

   // ==========================================================
   // state
   logic [15:0] iptr_q, iptr_d, acc_q, acc_d, tacc_q, tacc_d;
   logic [15:0] idx_q, idx_d, ext_q, ext_d, stk_q, stk_d;
   logic [7:0] bank_select_q, bank_select_d;
   crf_pkg::crf_flags_t cond_flags_q, cond_flags_d;
   crf_st_t st_q, st_d;
   logic [31:0] rdata_q, rdata_d;
   logic err_q, err_d;
   logic gpr_hit_q, gpr_hit_d;

   crf_pkg::crf_req_t req;
   logic wr, rd, setup;
   logic [7:0] ares;
   logic ah, an, az, av, ac, aarith;
   crf_pkg::crf_op_t op;
   logic [GW-1:0] gaddr;
   logic gwe;
   logic [7:0] grd;
   logic [15:0] bank_base;

   assign req = '{addr: {4'h0, paddr}, write: pwrite, wdata: pwdata};
   assign setup = psel && !penable;
   assign op = crf_pkg::crf_op_t'(pwdata[3:0]);

   // ==========================================================
   // operand path: byte ops on low bytes of acc and temp
   crf_alu u_alu (
      .a(acc_q[7:0]),
      .b(tacc_q[7:0]),
      .cin(cond_flags_q.c),
      .op(op),
      .res(ares),
      .h(ah),
      .n(an),
      .z(az),
      .v(av),
      .c(ac),
      .arith(aarith)
   );

   // ==========================================================
   // banked general registers
   assign bank_base = crf_bank_base(bank_select_q);
   // bank index wraps within the fitted banks
   assign gaddr = GW'({bank_select_q[4:0], pwdata[10:8]});
   // write lands at the access edge, like every other register
   assign gwe = wr && !err_q && (req.addr[11:0] == `CRF_OFF_GPR);
   crf_gpr_mem #(.BANKS(BANKS)) u_gpr (
      .pclk(pclk),
      .addr(gaddr),
      .we(gwe),
      .wdata(req.wdata[7:0]),
      .rdata(grd)
   );

   // ==========================================================
   // apb: one wait for memory reads, else zero-wait
   assign wr = psel && penable && pwrite && pready;
   assign rd = psel && penable && !pwrite && pready;
   assign pready = (st_q == CRF_ST_IDLE);
   assign pslverr = err_q && psel && penable;
   assign prdata = gpr_hit_q ? {24'h0, grd} : rdata_q;

   always_comb begin
      st_d = st_q;
      rdata_d = rdata_q;
      err_d = err_q;
      gpr_hit_d = 1'b0;
      unique case (st_q)
         CRF_ST_IDLE: begin
            if (setup) begin
               err_d = 1'b0;
               rdata_d = 32'h0;
               unique case (paddr)
                  `CRF_OFF_IPTR: rdata_d = {16'h0, iptr_q};
                  `CRF_OFF_ACC: rdata_d = {16'h0, acc_q};
                  `CRF_OFF_TACC: rdata_d = {16'h0, tacc_q};
                  `CRF_OFF_IDX: rdata_d = {16'h0, idx_q};
                  `CRF_OFF_EXT: rdata_d = {16'h0, ext_q};
                  `CRF_OFF_STK: rdata_d = {16'h0, stk_q};
                  `CRF_OFF_PSW: rdata_d = {16'h0, bank_select_q, cond_flags_q};
                  `CRF_OFF_OPC: rdata_d = 32'h0;
                  `CRF_OFF_IRQ: rdata_d = {31'h0, irq_take};
                  `CRF_OFF_MAP: rdata_d = {bank_base, 16'h0};
                  `CRF_OFF_GPR: begin
                     if (!pwrite) begin
                        st_d = CRF_ST_MEMRD;
                     end
                  end
                  default: err_d = 1'b1;
               endcase
            end
         end
         CRF_ST_MEMRD: begin
            st_d = CRF_ST_IDLE;
            gpr_hit_d = 1'b1;
         end
         default: st_d = CRF_ST_IDLE;
      endcase
   end

   // ==========================================================
   // register writes and flag update
   always_comb begin
      iptr_d = iptr_q;
      acc_d = acc_q;
      tacc_d = tacc_q;
      idx_d = idx_q;
      ext_d = ext_q;
      stk_d = stk_q;
      bank_select_d = bank_select_q;
      cond_flags_d = cond_flags_q;
      if (wr && !err_q) begin
         unique case (paddr)
            `CRF_OFF_IPTR: iptr_d = pwdata[15:0];
            `CRF_OFF_ACC: acc_d = pwdata[15:0];
            `CRF_OFF_TACC: tacc_d = pwdata[15:0];
            `CRF_OFF_IDX: idx_d = pwdata[15:0];
            `CRF_OFF_EXT: ext_d = pwdata[15:0];
            `CRF_OFF_STK: stk_d = pwdata[15:0];
            `CRF_OFF_PSW: begin
               bank_select_d = pwdata[15:8];
               cond_flags_d = pwdata[7:0];
            end
            `CRF_OFF_OPC: begin
               if (aarith) begin
                  // result returns to low byte, high byte kept
                  acc_d = {acc_q[15:8], ares};
                  cond_flags_d.c = ac;
                  cond_flags_d.n = an;
                  cond_flags_d.z = az;
                  if (op != crf_pkg::CRF_OP_SHL && op != crf_pkg::CRF_OP_SHR) begin
                     cond_flags_d.h = ah;
                     cond_flags_d.v = av;
                  end
               end
            end
            default: ;
         endcase
      end
   end

   // interrupt gate: enable flag and level above mask
   assign irq_take = irq_req && cond_flags_q.i
      && (crf_level(irq_level) < crf_level(cond_flags_q.il));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         iptr_q <= `CRF_RST_IPTR;
         acc_q <= 16'h0000;
         tacc_q <= 16'h0000;
         idx_q <= 16'h0000;
         ext_q <= 16'h0000;
         stk_q <= `CRF_RST_STK;
         bank_select_q <= 8'h00;
         cond_flags_q <= 8'h30;
         st_q <= CRF_ST_IDLE;
         rdata_q <= 32'h0;
         err_q <= 1'b0;
         gpr_hit_q <= 1'b0;
      end else begin
         iptr_q <= iptr_d;
         acc_q <= acc_d;
         tacc_q <= tacc_d;
         idx_q <= idx_d;
         ext_q <= ext_d;
         stk_q <= stk_d;
         bank_select_q <= bank_select_d;
         cond_flags_q <= cond_flags_d;
         st_q <= st_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
         gpr_hit_q <= gpr_hit_d;
      end
   end

   // ==========================================================
   // checks
   // reference adder kept apart from the alu, so a slip there shows
   logic op_wr, ref_add, ref_cin;
   logic [8:0] ref_sum, ref_ssum, ref_dif;
   logic [4:0] ref_low;
   assign op_wr = wr && !err_q && (paddr == `CRF_OFF_OPC);
   assign ref_add = op_wr && (op == crf_pkg::CRF_OP_ADD || op == crf_pkg::CRF_OP_ADDC);
   assign ref_cin = (op == crf_pkg::CRF_OP_ADDC) && cond_flags_q.c;
   assign ref_sum = {1'b0, acc_q[7:0]} + {1'b0, tacc_q[7:0]} + {8'h00, ref_cin};
   assign ref_low = {1'b0, acc_q[3:0]} + {1'b0, tacc_q[3:0]} + {4'h0, ref_cin};
   assign ref_dif = {1'b0, acc_q[7:0]} - {1'b0, tacc_q[7:0]};
   // sign-extended sum: top two bits disagree on signed overflow
   assign ref_ssum = {acc_q[7], acc_q[7:0]} + {tacc_q[7], tacc_q[7:0]} + {8'h00, ref_cin};

   chk_irq_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      !cond_flags_q.i |-> !irq_take) else $error("irq taken while disabled");
   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq_take |-> crf_level(irq_level) < crf_level(cond_flags_q.il))
      else $error("irq level not above mask");
   chk_irq_reset: assert property (@(posedge pclk) !presetn |=> !cond_flags_q.i)
      else $error("enable flag not cleared by reset");

   chk_iptr_reset: assert property (@(posedge pclk)
      !presetn |=> iptr_q == `CRF_RST_IPTR) else $error("pointer not at reset vector");
   chk_iptr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && paddr == `CRF_OFF_IPTR) |=> $stable(iptr_q)) else $error("pointer moved");

   chk_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (op_wr && aarith) |=> cond_flags_q.z == (acc_q[7:0] == 8'h00))
      else $error("zero flag wrong");
   chk_neg_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (op_wr && aarith) |=> cond_flags_q.n == acc_q[7])
      else $error("negative flag wrong");
   chk_add_carry: assert property (@(posedge pclk) disable iff (!presetn)
      ref_add |=> cond_flags_q.c == $past(ref_sum[8])) else $error("add carry wrong");
   chk_sub_borrow: assert property (@(posedge pclk) disable iff (!presetn)
      (op_wr && op == crf_pkg::CRF_OP_SUB) |=> cond_flags_q.c == $past(ref_dif[8]))
      else $error("sub borrow wrong");
   chk_add_half: assert property (@(posedge pclk) disable iff (!presetn)
      ref_add |=> cond_flags_q.h == $past(ref_low[4])) else $error("half carry wrong");
   chk_add_ovf: assert property (@(posedge pclk) disable iff (!presetn)
      ref_add |=> cond_flags_q.v == ($past(ref_ssum[8]) != $past(ref_ssum[7])))
      else $error("overflow flag wrong");
   chk_shift_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (op_wr && (op == crf_pkg::CRF_OP_SHL || op == crf_pkg::CRF_OP_SHR))
      |=> $stable(cond_flags_q.h) && $stable(cond_flags_q.v)) else $error("shift moved h or v");
   chk_shift_carry: assert property (@(posedge pclk) disable iff (!presetn)
      (op_wr && op == crf_pkg::CRF_OP_SHL) |=> cond_flags_q.c == $past(acc_q[7]))
      else $error("shift carry wrong");
   chk_shr_carry: assert property (@(posedge pclk) disable iff (!presetn)
      (op_wr && op == crf_pkg::CRF_OP_SHR) |=> cond_flags_q.c == $past(acc_q[0]))
      else $error("right shift carry wrong");

   chk_acc_high: assert property (@(posedge pclk) disable iff (!presetn)
      op_wr |=> $stable(acc_q[15:8])) else $error("byte op touched acc high");
   chk_opc_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (op_wr && !aarith) |=> $stable(acc_q) && $stable(cond_flags_q))
      else $error("idle op changed state");
   chk_tacc_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == `CRF_OFF_OPC) |=> $stable(tacc_q)) else $error("temp changed by op");
   chk_ptr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      op_wr |=> $stable(idx_q) && $stable(ext_q) && $stable(stk_q))
      else $error("pointer changed by op");
   chk_psw_read: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `CRF_OFF_PSW) |=> rdata_q[15:8] == bank_select_q)
      else $error("status word read wrong");

   chk_ready_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `CRF_OFF_GPR) |=> !pready ##1 pready)
      else $error("bank read wait wrong");
   chk_bank_base: assert property (@(posedge pclk) disable iff (!presetn)
      bank_base == `CRF_BANK_BASE + {8'h00, bank_select_q[4:0], 3'h0})
      else $error("bank base wrong");
   chk_gpr_byte: assert property (@(posedge pclk) disable iff (!presetn)
      (rd && gpr_hit_q) |-> prdata[31:8] == 24'h0)
      else $error("bank register wider than a byte");
endmodule

// [verilog/crf_cfg.svh]
`ifndef CRF_CFG_SVH
`define CRF_CFG_SVH
// register offsets on the apb bus (byte addresses)
`define CRF_OFF_IPTR 12'h000
`define CRF_OFF_ACC 12'h004
`define CRF_OFF_TACC 12'h008
`define CRF_OFF_IDX 12'h00C
`define CRF_OFF_EXT 12'h010
`define CRF_OFF_STK 12'h014
`define CRF_OFF_PSW 12'h018
`define CRF_OFF_OPC 12'h01C
`define CRF_OFF_IRQ 12'h020
`define CRF_OFF_GPR 12'h024
`define CRF_OFF_MAP 12'h028
// condition flag bit positions
`define CRF_BIT_C 0
`define CRF_BIT_V 1
`define CRF_BIT_Z 2
`define CRF_BIT_N 3
`define CRF_BIT_IL0 4
`define CRF_BIT_IL1 5
`define CRF_BIT_I 6
`define CRF_BIT_H 7
// reset values
`define CRF_RST_IPTR 16'hFFFD
`define CRF_RST_PSW 16'h0030
`define CRF_RST_STK 16'h0000
// memory map: i/o at bottom, data above, program from the top
`define CRF_IO_TOP 16'h007F
`define CRF_DATA_BASE 16'h0080
`define CRF_BANK_BASE 16'h0100
`define CRF_BANK_SPAN 8
`endif

// [verilog/crf_pkg.sv]
package crf_pkg;
   typedef enum logic [3:0] {
      CRF_OP_ADD = 4'h0,
      CRF_OP_ADDC = 4'h1,
      CRF_OP_SUB = 4'h2,
      CRF_OP_SUBC = 4'h3,
      CRF_OP_SHL = 4'h4,
      CRF_OP_SHR = 4'h5,
      CRF_OP_NOP = 4'hF
   } crf_op_t;

   typedef struct packed {
      logic [15:0] addr;
      logic write;
      logic [31:0] wdata;
   } crf_req_t;

   typedef struct packed {
      logic h;
      logic i;
      logic [1:0] il;
      logic n;
      logic z;
      logic v;
      logic c;
   } crf_flags_t;
endpackage

// [verilog/crf_alu.sv]
`timescale 1ns/100ps
`include "crf_cfg.svh"
module crf_alu (
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   input wire crf_pkg::crf_op_t op,
   output logic [7:0] res,
   output logic h,
   output logic n,
   output logic z,
   output logic v,
   output logic c,
   output logic arith
);
   logic [8:0] full;
   logic [4:0] low;
   logic cuse;
   always_comb begin
      cuse = (op == crf_pkg::CRF_OP_ADDC || op == crf_pkg::CRF_OP_SUBC) ? cin : 1'b0;
      full = 9'h000;
      low = 5'h00;
      res = 8'h00;
      c = 1'b0;
      v = 1'b0;
      h = 1'b0;
      arith = 1'b1;
      unique case (op)
         crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADDC: begin
            full = {1'b0, a} + {1'b0, b} + {8'h00, cuse};
            low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cuse};
            res = full[7:0];
            c = full[8];
            h = low[4];
            v = (a[7] == b[7]) && (res[7] != a[7]);
         end
         crf_pkg::CRF_OP_SUB, crf_pkg::CRF_OP_SUBC: begin
            full = {1'b0, a} - {1'b0, b} - {8'h00, cuse};
            low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cuse};
            res = full[7:0];
            c = full[8];
            h = low[4];
            v = (a[7] != b[7]) && (res[7] != a[7]);
         end
         crf_pkg::CRF_OP_SHL: begin
            res = {a[6:0], 1'b0};
            c = a[7];
         end
         crf_pkg::CRF_OP_SHR: begin
            res = {1'b0, a[7:1]};
            c = a[0];
         end
         default: begin
            arith = 1'b0;
         end
      endcase
      n = res[7];
      z = (res == 8'h00);
   end
endmodule

// [verilog/crf_gpr_mem.sv]
`timescale 1ns/100ps
module crf_gpr_mem #(
   parameter int BANKS = 16
) (
   input wire logic pclk,
   input wire logic [$clog2(BANKS*8)-1:0] addr,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   // registered read port keeps the bus data output a flop
   logic [7:0] mem [0:BANKS*8-1];
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule

// [verif/crf_irq_src.sv]
`timescale 1ns/100ps
// ==========================================
// requester on the far side of the core
// ==========================================
// it holds each request as a level, so the core sees a steady request
module crf_irq_src (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] lvl_cmd,
   input wire logic req_cmd,
   output logic [1:0] irq_level,
   output logic irq_req
);
   logic [1:0] lvl_d;
   logic req_d;
   always_comb begin
      lvl_d = lvl_cmd;
      req_d = req_cmd;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_level <= 2'h0;
         irq_req <= 1'b0;
      end else begin
         irq_level <= lvl_d;
         irq_req <= req_d;
      end
   end
endmodule

// [verif/test_cpu_core_registers_flags.sv]
`timescale 1ns/100ps
`include "crf_cfg.svh"
module test_cpu_core_registers_flags;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic irq_req, irq_take, req_cmd, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] irq_level, lvl_cmd;
   logic [4:0] mk;
   int failures, total_checks, k, m, i, r;
   // ==========================================
   // alu cases: op, a, b, result, flags h n z v c
   // ==========================================
   // addc and subc lean on the carry left by the case before them
   logic [3:0] t_op [10] = '{4'h0, 4'h0, 4'h1, 4'h0, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h2};
   logic [7:0] t_a [10] = '{8'h08, 8'h80, 8'h01, 8'h7F, 8'h10, 8'h00, 8'h05, 8'h81, 8'h01, 8'h80};
   logic [7:0] t_b [10] = '{8'h08, 8'h80, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h00, 8'h00, 8'h01};
   logic [7:0] t_r [10] = '{8'h10, 8'h00, 8'h03, 8'h80, 8'h0F, 8'hFF, 8'h02, 8'h02, 8'h00, 8'h7F};
   logic [4:0] t_f [10] = '{5'h10, 5'h07, 5'h00, 5'h1A, 5'h10, 5'h19, 5'h00, 5'h01, 5'h05, 5'h12};
   logic [11:0] offs [5] = '{`CRF_OFF_ACC, `CRF_OFF_TACC, `CRF_OFF_IDX, `CRF_OFF_EXT, `CRF_OFF_STK};
   logic [3:0] bk [3] = '{4'h0, 4'h5, 4'hF};

   crf_core #(.BANKS(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_level(irq_level), .irq_req(irq_req), .irq_take(irq_take));
   crf_irq_src src (.pclk(pclk), .presetn(presetn), .lvl_cmd(lvl_cmd), .req_cmd(req_cmd),
      .irq_level(irq_level), .irq_req(irq_req));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ==========================================
   // tasks
   // ==========================================
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ready is awaited, never assumed; bank reads add a wait cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         failures++;
         $display("ERROR t=%0t no ready", $time);
         wrap_up();
      end
   endtask
   function automatic logic [1:0] lvl(input logic [1:0] x);
      lvl = x[1] ? x : 2'h1;
   endfunction
   // ==========================================
   // main sequence
   // ==========================================
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      lvl_cmd = 2'h0;
      req_cmd = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CRF_OFF_IPTR, 32'h0);
      check(rd, 32'h0000FFFD);
      apb(1'b0, `CRF_OFF_PSW, 32'h0);
      check(rd, 32'h00000030);
      $display("test reset values done");
      for (k = 0; k < 5; k++) begin
         apb(1'b1, offs[k], {16'h0, 16'h1234 + 16'(k) * 16'h1111});
         apb(1'b0, offs[k], 32'h0);
         check(rd, {16'h0, 16'h1234 + 16'(k) * 16'h1111});
      end
      $display("test pointer registers done");
      for (k = 0; k < 10; k++) begin
         apb(1'b1, `CRF_OFF_ACC, {16'h0, 8'h5A, t_a[k]});
         apb(1'b1, `CRF_OFF_TACC, {16'h0, 8'hA5, t_b[k]});
         apb(1'b1, `CRF_OFF_OPC, {28'h0, t_op[k]});
         apb(1'b0, `CRF_OFF_ACC, 32'h0);
         check(rd, {16'h0, 8'h5A, t_r[k]});
         apb(1'b0, `CRF_OFF_PSW, 32'h0);
         mk = (t_op[k] > 4'h3) ? 5'h0D : 5'h1F;
         check({27'h0, {rd[7], rd[3], rd[2], rd[1], rd[0]} & mk}, {27'h0, t_f[k] & mk});
      end
      // the nop code F must leave acc alone; flags are not read back
      apb(1'b1, `CRF_OFF_OPC, 32'h0000_000F);
      apb(1'b0, `CRF_OFF_ACC, 32'h0);
      check(rd, {16'h0, 8'h5A, t_r[9]});
      $display("test alu flags done");
      // masks 00 and 01 share the top level, so nothing may pass them
      for (m = 0; m < 4; m++) begin
         for (i = 0; i < 2; i++) begin
            for (r = 0; r < 4; r++) begin
               apb(1'b1, `CRF_OFF_PSW, {24'h0, 1'b0, i[0], m[1:0], 4'h0});
               lvl_cmd <= r[1:0];
               req_cmd <= 1'b1;
               repeat (2) @(posedge pclk);
               check({31'h0, irq_take}, {31'h0, i[0] && (lvl(r[1:0]) < lvl(m[1:0]))});
            end
         end
      end
      apb(1'b1, `CRF_OFF_PSW, 32'h0000_0070);
      lvl_cmd <= 2'h2;
      repeat (2) @(posedge pclk);
      apb(1'b0, `CRF_OFF_IRQ, 32'h0);
      check(rd, 32'h1);
      req_cmd <= 1'b0;
      repeat (2) @(posedge pclk);
      check({31'h0, irq_take}, 32'h0);
      $display("test interrupt gating done");
      for (k = 0; k < 3; k++) begin
         apb(1'b1, `CRF_OFF_PSW, {20'h0, bk[k], 8'h00});
         apb(1'b1, `CRF_OFF_GPR, {21'h0, 3'h6, bk[k], 4'hC});
         apb(1'b0, `CRF_OFF_MAP, 32'h0);
         check({16'h0, rd[31:16]}, 32'h0100 + 32'(bk[k]) * 32'h8);
      end
      for (k = 0; k < 3; k++) begin
         apb(1'b1, `CRF_OFF_PSW, {20'h0, bk[k], 8'h00});
         apb(1'b0, `CRF_OFF_GPR, {21'h0, 3'h6, 8'h00});
         check({24'h0, rd[7:0]}, {24'h0, bk[k], 4'hC});
      end
      $display("test register banks done");
      // a mid-run reset must drop the enable flag again
      apb(1'b1, `CRF_OFF_PSW, 32'h0000_0040);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CRF_OFF_PSW, 32'h0);
      check(rd, {16'h0, `CRF_RST_PSW});
      apb(1'b0, `CRF_OFF_IPTR, 32'h0);
      check(rd, {16'h0, `CRF_RST_IPTR});
      $display("test mid-run reset done");
      apb(1'b1, 12'h02C, 32'h0000FFFF);
      check({31'h0, er}, 32'h1);
      apb(1'b0, 12'h02C, 32'h0);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      $display("test unmapped access done");
      wrap_up();
   end
endmodule
